// ---- logic/pmc_top.v ----
// modem control register bank with transmit and receive bit paths
`timescale 1ns/10ps
`default_nettype none
`include "pmc_regs.vh"

module pmc_top #(
	parameter BIT_CYCLES = `PMC_CLK_HZ / `PMC_BIT_RATE
) (
	input wire clk, // 20 MHz device clock
	input wire rst_n, // async reset, active low
	input wire [7:0] addr, // register address
	input wire [7:0] wr_data, // write data
	input wire wr_stb, // one-cycle write strobe
	input wire rd_stb, // one-cycle read strobe
	output wire [7:0] rd_data, // read data, cycle after rd_stb
	input wire rx_bit_in, // demodulated bit, from pin
	input wire rx_bit_stb, // demodulator bit strobe, from pin
	input wire raw_mark_in, // unscrambled mark detect level, pin
	output wire [3:0] rx_gain_code, // receive gain step
	output wire [3:0] tx_gain_code, // transmit gain step, 0 = off
	output wire inverted_out_enable, // inverted line driver on
	output wire tx_lockup_prevent, // transmit lock-up guard on
	output wire tx_scrambler_on, // scrambler in path
	output wire [1:0] tx_equaliser_level, // transmit equaliser
	output wire tx_modulator_on, // modulator output enabled
	output wire tx_band_select, // 1 = high channel
	output wire rx_lockup_prevent, // receive lock-up guard on
	output wire rx_descrambler_on, // descrambler in path
	output wire [1:0] rx_equaliser_level, // receive equaliser
	output wire rx_receiver_on, // receiver enabled
	output wire channel_band_select, // receive band, 1 = high
	output wire [1:0] tx_phase_step, // phase change in 90 degree units
	output wire tx_symbol_stb, // one-cycle pulse per dibit
	output wire interrupt_out_n // interrupt, active low
);

	// cut to the timer width on purpose; default count fits in 15 bits
	localparam integer BIT_LAST_W = BIT_CYCLES - 1;
	localparam [14:0] BIT_LAST = BIT_LAST_W[14:0];

	// ****************************************************************
	// settings registers
	// ****************************************************************
	reg [7:0] gain_q;
	reg [7:0] tx_mode_q;
	reg [7:0] rx_mode_q;
	reg [7:0] mask_q;
	reg [7:0] tx_buf_q;
	reg tx_buf_full_q;
	reg [7:0] rd_data_q;
	reg [6:0] flags_q;
	reg [6:0] flags_d;
	reg irq_n_q;

	wire wr_gain = wr_stb && (addr == `PMC_ADDR_GAIN);
	wire wr_txb = wr_stb && (addr == `PMC_ADDR_TX_BYTE);
	wire rd_flags = rd_stb && (addr == `PMC_ADDR_FLAGS);
	wire rd_rxb = rd_stb && (addr == `PMC_ADDR_RX_BYTE);
	wire tx_en = tx_mode_q[`PMC_MODE_ENABLE];
	wire rx_en = rx_mode_q[`PMC_MODE_ENABLE];

	// writes land on the next edge; reserved bits stored as zero
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gain_q <= `PMC_RESET_BYTE;
			tx_mode_q <= `PMC_RESET_BYTE;
			rx_mode_q <= `PMC_RESET_BYTE;
			mask_q <= `PMC_RESET_BYTE;
		end else if (wr_stb) begin
			if (wr_gain)
				gain_q <= wr_data;
			if (addr == `PMC_ADDR_TX_MODE)
				tx_mode_q <= wr_data & `PMC_WR_MASK_TX;
			if (addr == `PMC_ADDR_RX_MODE)
				rx_mode_q <= wr_data & `PMC_WR_MASK_RX;
			if (addr == `PMC_ADDR_MASK)
				mask_q <= wr_data & `PMC_WR_MASK_IRQ;
		end
	end

	// ****************************************************************
	// transmit bit timing and byte shifter
	// ****************************************************************
	reg [14:0] tx_tmr_q;
	reg [7:0] tx_sh_q;
	reg [2:0] tx_cnt_q;
	wire tx_tick = tx_en && (tx_tmr_q == BIT_LAST);
	wire tx_load = tx_tick && (tx_cnt_q == 3'd0);
	// an empty buffer at a byte boundary sends idle ones
	wire [7:0] tx_next_byte = tx_buf_full_q ? tx_buf_q : `PMC_IDLE_BYTE;
	wire tx_raw_bit = tx_load ? tx_next_byte[7] : tx_sh_q[7];

	// bit period counter; path parks while the modulator is off
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_tmr_q <= 15'h0000;
			tx_cnt_q <= 3'h0;
			tx_sh_q <= `PMC_RESET_BYTE;
		end else if (!tx_en) begin
			tx_tmr_q <= 15'h0000;
			tx_cnt_q <= 3'h0;
		end else begin
			tx_tmr_q <= tx_tick ? 15'h0000 : tx_tmr_q + 15'h0001;
			if (tx_tick) begin
				tx_cnt_q <= tx_cnt_q + 3'h1;
				if (tx_load)
					tx_sh_q <= {tx_next_byte[6:0], 1'b0};
				else
					tx_sh_q <= {tx_sh_q[6:0], 1'b0};
			end
		end
	end

	// holding buffer: host fills it while the shifter sends
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_buf_q <= `PMC_RESET_BYTE;
			tx_buf_full_q <= 1'b0;
		end else if (wr_txb) begin
			tx_buf_q <= wr_data;
			tx_buf_full_q <= 1'b1;
		end else if (tx_load) begin
			tx_buf_full_q <= 1'b0;
		end
	end

	// ****************************************************************
	// scrambler with lock-up guard
	// ****************************************************************
	reg [16:0] scr_q;
	reg [6:0] scr_ones_q;
	reg scr_inv_q;
	wire scr_on = tx_mode_q[`PMC_MODE_SCRAMB];
	wire scr_guard = tx_mode_q[`PMC_MODE_LOCKUP];
	wire scr_in = tx_raw_bit ^ (scr_inv_q & scr_guard);
	wire scr_out = scr_on ?
		(scr_in ^ scr_q[`PMC_TAP_A] ^ scr_q[`PMC_TAP_B]) :
		tx_raw_bit;
	wire scr_hit = scr_out && (scr_ones_q == `PMC_LOCKUP_LAST);

	// run counter watches the output so a stuck state is broken
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scr_q <= 17'h0_0000;
			scr_ones_q <= 7'h00;
			scr_inv_q <= 1'b0;
		end else if (tx_tick) begin
			scr_q <= {scr_q[15:0], scr_out};
			if (!scr_guard || !scr_on || !scr_out) begin
				scr_ones_q <= 7'h00;
				scr_inv_q <= 1'b0;
			end else if (scr_hit) begin
				scr_ones_q <= 7'h00;
				scr_inv_q <= 1'b1;
			end else begin
				scr_ones_q <= scr_ones_q + 7'h01;
				scr_inv_q <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// dibit pairing and phase coding
	// ****************************************************************
	reg dib_half_q;
	reg dib_first_q;
	reg [1:0] phase_q;
	reg sym_stb_q;
	reg [1:0] phase_d;

	// left digit is the earlier scrambler bit
	always @* begin
		case ({dib_first_q, scr_out})
		2'b00: phase_d = 2'd1; // +90
		2'b01: phase_d = 2'd0; // 0
		2'b11: phase_d = 2'd3; // +270
		2'b10: phase_d = 2'd2; // +180
		default: phase_d = 2'd0;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dib_half_q <= 1'b0;
			dib_first_q <= 1'b0;
			phase_q <= 2'd0;
			sym_stb_q <= 1'b0;
		end else begin
			sym_stb_q <= tx_tick && dib_half_q;
			if (!tx_en) begin
				dib_half_q <= 1'b0;
			end else if (tx_tick) begin
				dib_half_q <= ~dib_half_q;
				if (dib_half_q)
					phase_q <= phase_d;
				else
					dib_first_q <= scr_out;
			end
		end
	end

	// ****************************************************************
	// receive pin synchronisers
	// ****************************************************************
	reg [1:0] rxd_sync_q;
	reg [2:0] rxs_sync_q;
	reg [2:0] mark_sync_q;

	// first stage feeds only the second
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rxd_sync_q <= 2'b00;
			rxs_sync_q <= 3'b000;
			mark_sync_q <= 3'b000;
		end else begin
			rxd_sync_q <= {rxd_sync_q[0], rx_bit_in};
			rxs_sync_q <= {rxs_sync_q[1:0], rx_bit_stb};
			mark_sync_q <= {mark_sync_q[1:0], raw_mark_in};
		end
	end

	wire rx_tick = rx_en && rxs_sync_q[1] && !rxs_sync_q[2];
	wire mark_chg = rx_en && (mark_sync_q[1] ^ mark_sync_q[2]);

	// ****************************************************************
	// descrambler and receive byte assembly
	// ****************************************************************
	reg [16:0] dsc_q;
	reg [6:0] dsc_ones_q;
	reg dsc_inv_q;
	reg [7:0] rx_sh_q;
	reg [2:0] rx_cnt_q;
	reg [7:0] rx_byte_q;
	reg rx_pend_q;
	wire dsc_on = rx_mode_q[`PMC_MODE_SCRAMB];
	wire dsc_guard = rx_mode_q[`PMC_MODE_LOCKUP];
	wire dsc_in = rxd_sync_q[1];
	wire dsc_out = dsc_on ?
		(dsc_in ^ dsc_q[`PMC_TAP_A] ^ dsc_q[`PMC_TAP_B] ^
		(dsc_inv_q & dsc_guard)) : dsc_in;
	wire rx_done = rx_tick && (rx_cnt_q == 3'd7);

	// guard counts ones arriving at the descrambler input
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dsc_q <= 17'h0_0000;
			dsc_ones_q <= 7'h00;
			dsc_inv_q <= 1'b0;
		end else if (rx_tick) begin
			dsc_q <= {dsc_q[15:0], dsc_in};
			if (!dsc_guard || !dsc_on || !dsc_in) begin
				dsc_ones_q <= 7'h00;
				dsc_inv_q <= 1'b0;
			end else if (dsc_ones_q == `PMC_LOCKUP_LAST) begin
				dsc_ones_q <= 7'h00;
				dsc_inv_q <= 1'b1;
			end else begin
				dsc_ones_q <= dsc_ones_q + 7'h01;
				dsc_inv_q <= 1'b0;
			end
		end
	end

	// bytes fill from bit 7; a completed byte beats a same-cycle read
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_sh_q <= `PMC_RESET_BYTE;
			rx_cnt_q <= 3'h0;
			rx_byte_q <= `PMC_RESET_BYTE;
			rx_pend_q <= 1'b0;
		end else begin
			if (!rx_en) begin
				rx_cnt_q <= 3'h0;
			end else if (rx_tick) begin
				rx_sh_q <= {rx_sh_q[6:0], dsc_out};
				rx_cnt_q <= rx_cnt_q + 3'h1;
			end
			if (rx_done) begin
				rx_byte_q <= {rx_sh_q[6:0], dsc_out};
				rx_pend_q <= 1'b1;
			end else if (rd_rxb) begin
				rx_pend_q <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// flags, interrupt and read port
	// ****************************************************************
	// new events win over the clear caused by reading the flags
	always @* begin
		flags_d = rd_flags ? 7'h00 : flags_q;
		if (tx_load) begin
			flags_d[`PMC_FLAG_TX_RDY] = tx_buf_full_q |
				flags_d[`PMC_FLAG_TX_RDY];
			flags_d[`PMC_FLAG_TX_UNF] = !tx_buf_full_q |
				flags_d[`PMC_FLAG_TX_UNF];
		end
		if (rx_done) begin
			flags_d[`PMC_FLAG_RX_RDY] = 1'b1;
			flags_d[`PMC_FLAG_RX_OVF] = rx_pend_q |
				flags_d[`PMC_FLAG_RX_OVF];
		end
		if (mark_chg)
			flags_d[`PMC_FLAG_MARK] = 1'b1;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= 7'h00;
			irq_n_q <= 1'b1;
			rd_data_q <= `PMC_RESET_BYTE;
		end else begin
			flags_q <= flags_d;
			irq_n_q <= ~|(flags_d & mask_q[6:0]);
			if (rd_flags)
				rd_data_q <= {1'b0, flags_q};
			else if (rd_rxb)
				rd_data_q <= rx_byte_q;
			else
				rd_data_q <= `PMC_RESET_BYTE;
		end
	end

	// ****************************************************************
	// outputs straight from the setting, phase, strobe, interrupt and read data flops
	// ****************************************************************
	assign rd_data = rd_data_q;
	assign rx_gain_code = gain_q[3:0];
	assign tx_gain_code = gain_q[7:4];
	assign inverted_out_enable = tx_mode_q[`PMC_MODE_INV_OUT];
	assign tx_lockup_prevent = tx_mode_q[`PMC_MODE_LOCKUP];
	assign tx_scrambler_on = tx_mode_q[`PMC_MODE_SCRAMB];
	assign tx_equaliser_level = tx_mode_q[3:2];
	assign tx_modulator_on = tx_mode_q[`PMC_MODE_ENABLE];
	assign tx_band_select = tx_mode_q[`PMC_MODE_BAND];
	assign rx_lockup_prevent = rx_mode_q[`PMC_MODE_LOCKUP];
	assign rx_descrambler_on = rx_mode_q[`PMC_MODE_SCRAMB];
	assign rx_equaliser_level = rx_mode_q[3:2];
	assign rx_receiver_on = rx_mode_q[`PMC_MODE_ENABLE];
	assign channel_band_select = rx_mode_q[`PMC_MODE_BAND];
	assign tx_phase_step = phase_q;
	assign tx_symbol_stb = sym_stb_q;
	assign interrupt_out_n = irq_n_q;

endmodule
`default_nettype wire

// ---- logic/pmc_regs.vh ----
// register map, field positions and timing constants for the modem control
// Overview of operation
// - gain low nibble picks one of sixteen receive input gain steps
// - gain high nibble picks transmit gain; code zero holds output at bias
// - transmit byte is double buffered, host gets eight bit periods
// - each byte goes out as four dibits, bit 7 end first
// - dibit 00 +90, 01 0, 11 +270, 10 +180 degrees phase change
// - first bit out of the scrambler is the left dibit digit
// - transmit mode bit 6 enables the inverted line output
// - transmit lock-up guard inverts next input after 64 output ones
// - transmit mode bit 4 routes data through the scrambler
// - transmit mode bits 3:2 select transmit equaliser level
// - transmit mode bit 1 enables modulator; transmit flags only then
// - transmit mode bit 0 selects low or high channel
// - receive lock-up guard inverts next output after 64 input ones
// - receive mode bit 4 routes data through the descrambler
// - receive mode bits 3:2 select receive equaliser level
// - receive mode bit 1 enables receiver; receive flags only then
// - receive mode bit 0 selects low or high receive channel
// - each mask bit 6..0 enables the interrupt of its flag
// - interrupt low while any flag and mask both set; flag read clears
// - ready flag when buffer frees; underflow if not refilled in time
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define PMC_ADDR_GAIN 8'he2
`define PMC_ADDR_TX_BYTE 8'he3
`define PMC_ADDR_TX_MODE 8'he7
`define PMC_ADDR_RX_MODE 8'he8
`define PMC_ADDR_RX_BYTE 8'hea
`define PMC_ADDR_MASK 8'hee
`define PMC_ADDR_FLAGS 8'hef

// ****************************************************************
// reset values and field positions
// ****************************************************************
`define PMC_RESET_BYTE 8'h00
`define PMC_IDLE_BYTE 8'hff
`define PMC_WR_MASK_TX 8'h7f
`define PMC_WR_MASK_RX 8'h3f
`define PMC_WR_MASK_IRQ 8'h7f
`define PMC_MODE_INV_OUT 6
`define PMC_MODE_LOCKUP 5
`define PMC_MODE_SCRAMB 4
`define PMC_MODE_EQ_HI 3
`define PMC_MODE_EQ_LO 2
`define PMC_MODE_ENABLE 1
`define PMC_MODE_BAND 0
`define PMC_FLAG_RX_OVF 4
`define PMC_FLAG_RX_RDY 3
`define PMC_FLAG_TX_UNF 2
`define PMC_FLAG_TX_RDY 1
`define PMC_FLAG_MARK 0

// ****************************************************************
// scrambler and timing
// ****************************************************************
`define PMC_TAP_A 13
`define PMC_TAP_B 16
`define PMC_LOCKUP_LAST 7'h3f
`define PMC_CLK_HZ 20000000
`define PMC_BIT_RATE 1200

`endif

// ---- sim/pmc_sva.sv ----
// assertion checker for the modem control register bank
`timescale 1ns/10ps
`default_nettype none
`include "pmc_regs.vh"
module pmc_sva #(
	parameter BIT_CYCLES = 8
) (
	input wire logic clk, // clock
	input wire logic rst_n, // reset, low
	input wire logic [7:0] addr, // address
	input wire logic [7:0] wr_data, // write data
	input wire logic wr_stb, // write strobe
	input wire logic rd_stb, // read strobe
	input wire logic [3:0] rx_gain_code, // rx gain
	input wire logic [3:0] tx_gain_code, // tx gain
	input wire logic inverted_out_enable, // tx mode 6
	input wire logic tx_lockup_prevent, // tx mode 5
	input wire logic tx_scrambler_on, // tx mode 4
	input wire logic [1:0] tx_equaliser_level, // tx mode 3:2
	input wire logic tx_modulator_on, // tx mode 1
	input wire logic tx_band_select, // tx mode 0
	input wire logic rx_lockup_prevent, // rx mode 5
	input wire logic rx_descrambler_on, // rx mode 4
	input wire logic [1:0] rx_equaliser_level, // rx mode 3:2
	input wire logic rx_receiver_on, // rx mode 1
	input wire logic channel_band_select, // rx mode 0
	input wire logic [1:0] tx_phase_step, // phase step
	input wire logic tx_symbol_stb, // dibit strobe
	input wire logic interrupt_out_n // irq, low
);
	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// mode fields gathered so one compare covers the register
	wire [6:0] txm = {inverted_out_enable, tx_lockup_prevent,
		tx_scrambler_on, tx_equaliser_level, tx_modulator_on, tx_band_select};
	wire [5:0] rxm = {rx_lockup_prevent, rx_descrambler_on,
		rx_equaliser_level, rx_receiver_on, channel_band_select};
	a_gain_load:
		assert property (wr_stb && addr == `PMC_ADDR_GAIN
			|=> {tx_gain_code, rx_gain_code} == $past(wr_data))
		else $error("gain write not applied");
	a_txmode_load:
		assert property (wr_stb && addr == `PMC_ADDR_TX_MODE
			|=> txm == $past(wr_data[6:0]))
		else $error("transmit mode write not applied");
	a_rxmode_load:
		assert property (wr_stb && addr == `PMC_ADDR_RX_MODE
			|=> rxm == $past(wr_data[5:0]))
		else $error("receive mode write not applied");
	a_settings_hold:
		assert property (!wr_stb
			|=> $stable({tx_gain_code, rx_gain_code, txm, rxm}))
		else $error("setting moved without a write");
	// spacing holds while two bit periods exceed eight clocks
	a_symbol_gap:
		assert property (tx_symbol_stb |=> !tx_symbol_stb [*8])
		else $error("dibit strobes too close");
	a_symbol_enabled:
		assert property (tx_symbol_stb |-> $past(tx_modulator_on))
		else $error("dibit sent with modulator off");
	a_phase_hold:
		assert property (!tx_symbol_stb |-> $stable(tx_phase_step))
		else $error("phase step moved between symbols");
	a_mask_quiet:
		assert property (wr_stb && addr == `PMC_ADDR_MASK
			&& wr_data[6:0] == 7'h00 |=> ##1 interrupt_out_n)
		else $error("interrupt with all masks clear");
	a_read_clears:
		assert property (rd_stb && addr == `PMC_ADDR_FLAGS
			&& !tx_modulator_on && !rx_receiver_on |=> ##1 interrupt_out_n)
		else $error("flag read left interrupt set");
	// main scenarios reached
	c_symbol: cover property (tx_symbol_stb);
	c_irq: cover property ($fell(interrupt_out_n));
	c_rx_read: cover property (rd_stb && addr == `PMC_ADDR_RX_BYTE);
endmodule
bind pmc_top pmc_sva #(.BIT_CYCLES(BIT_CYCLES)) u_sva (
	.clk(clk),
	.rst_n(rst_n),
	.addr(addr),
	.wr_data(wr_data),
	.wr_stb(wr_stb),
	.rd_stb(rd_stb),
	.rx_gain_code(rx_gain_code),
	.tx_gain_code(tx_gain_code),
	.inverted_out_enable(inverted_out_enable),
	.tx_lockup_prevent(tx_lockup_prevent),
	.tx_scrambler_on(tx_scrambler_on),
	.tx_equaliser_level(tx_equaliser_level),
	.tx_modulator_on(tx_modulator_on),
	.tx_band_select(tx_band_select),
	.rx_lockup_prevent(rx_lockup_prevent),
	.rx_descrambler_on(rx_descrambler_on),
	.rx_equaliser_level(rx_equaliser_level),
	.rx_receiver_on(rx_receiver_on),
	.channel_band_select(channel_band_select),
	.tx_phase_step(tx_phase_step),
	.tx_symbol_stb(tx_symbol_stb),
	.interrupt_out_n(interrupt_out_n)
);
`default_nettype wire

// ---- sim/pmc_demod.sv ----
// demodulator stand-in that feeds received bits to the block
`timescale 1ns/10ps
`default_nettype none
module pmc_demod (
	input wire logic clk, // device clock
	output logic rx_bit_in, // demodulated bit
	output logic rx_bit_stb // bit strobe
);
	// idle with strobe low
	initial begin
		rx_bit_in = 1'b1;
		rx_bit_stb = 1'b0;
	end
	// bit 7 first; data settles before the strobe edge
	task send(input logic [7:0] b);
		integer i;
		for (i = 7; i >= 0; i--) begin
			@(posedge clk);
			rx_bit_in <= b[i];
			repeat (3) @(posedge clk);
			rx_bit_stb <= 1'b1;
			repeat (4) @(posedge clk);
			rx_bit_stb <= 1'b0;
			rx_bit_in <= ~b[i]; // no stale bit left on the line
		end
	endtask
endmodule
`default_nettype wire

// ---- sim/psk_modem_control_registers_tb.sv ----
// self-checking bench for the modem control register bank
`timescale 1ns/10ps
`default_nettype none
`include "pmc_regs.vh"
module psk_modem_control_registers_tb;
	logic clk, rst_n, wr_stb, rd_stb, raw_mark_in;
	logic [7:0] addr, wr_data, v, e, a, b, c;
	logic [23:0] w;
	logic [16:0] s, d;
	wire [7:0] rd_data;
	wire [3:0] rx_gain_code, tx_gain_code;
	wire [1:0] tx_equaliser_level, rx_equaliser_level, tx_phase_step;
	wire rx_bit_in, rx_bit_stb, inverted_out_enable, tx_lockup_prevent;
	wire tx_scrambler_on, tx_modulator_on, tx_band_select, rx_lockup_prevent;
	wire rx_descrambler_on, rx_receiver_on, channel_band_select;
	wire tx_symbol_stb, interrupt_out_n;
	wire [7:0] txm = {1'b0, inverted_out_enable, tx_lockup_prevent,
		tx_scrambler_on, tx_equaliser_level, tx_modulator_on, tx_band_select};
	wire [7:0] rxm = {2'b00, rx_lockup_prevent, rx_descrambler_on,
		rx_equaliser_level, rx_receiver_on, channel_band_select};
	integer errors = 0, cmp_count = 0, seed = 21, i;
	logic [1:0] got_q[$];
	pmc_top #(.BIT_CYCLES(8)) dut (
		.clk(clk),
		.rst_n(rst_n),
		.addr(addr),
		.wr_data(wr_data),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.rd_data(rd_data),
		.rx_bit_in(rx_bit_in),
		.rx_bit_stb(rx_bit_stb),
		.raw_mark_in(raw_mark_in),
		.rx_gain_code(rx_gain_code),
		.tx_gain_code(tx_gain_code),
		.inverted_out_enable(inverted_out_enable),
		.tx_lockup_prevent(tx_lockup_prevent),
		.tx_scrambler_on(tx_scrambler_on),
		.tx_equaliser_level(tx_equaliser_level),
		.tx_modulator_on(tx_modulator_on),
		.tx_band_select(tx_band_select),
		.rx_lockup_prevent(rx_lockup_prevent),
		.rx_descrambler_on(rx_descrambler_on),
		.rx_equaliser_level(rx_equaliser_level),
		.rx_receiver_on(rx_receiver_on),
		.channel_band_select(channel_band_select),
		.tx_phase_step(tx_phase_step),
		.tx_symbol_stb(tx_symbol_stb),
		.interrupt_out_n(interrupt_out_n)
	);
	pmc_demod demod (
		.clk(clk),
		.rx_bit_in(rx_bit_in),
		.rx_bit_stb(rx_bit_stb)
	);
	// ****************************************************************
	// clock, watchdog, monitor and helpers
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// whole run is under a thousand cycles; five thousand is a hang
	initial begin
		#(50 * 5000);
		errors++;
		print_verdict();
	end
	// each dibit strobe hands its phase step to the scoreboard
	always @(posedge clk)
		if (tx_symbol_stb === 1'b1)
			got_q.push_back(tx_phase_step);
	// expected phase step, in quarter turns, of one dibit
	function logic [1:0] ph(input logic [1:0] d);
		ph = d[1] ? d : {1'b0, ~d[0]};
	endfunction
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk);
		addr <= ad;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		#1;
	endtask
	// read data stand only in the cycle after the strobe
	task rd(input logic [7:0] ad, output logic [7:0] d);
		@(posedge clk);
		addr <= ad;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 d = rd_data;
	endtask
	task print_verdict;
		$display("comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		raw_mark_in = 1'b0;
		addr = 8'h00;
		wr_data = 8'h00;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk({7'h00, interrupt_out_n}, 8'h01);
		// every code on both gain nibbles
		for (i = 0; i < 16; i++) begin
			v = {~i[3:0], i[3:0]};
			wr(`PMC_ADDR_GAIN, v);
			chk({tx_gain_code, rx_gain_code}, v);
		end
		$display("test gain done");
		// every equaliser level, enable bit 1 held zero, random rest, reserved bits left zero
		for (i = 0; i < 4; i++) begin
			v = $random(seed);
			v[3:1] = {i[1:0], 1'b0};
			wr(`PMC_ADDR_TX_MODE, v & 8'h7f);
			wr(`PMC_ADDR_RX_MODE, v & 8'h3f);
			chk(txm, v & 8'h7f);
			chk(rxm, v & 8'h3f);
		end
		e = v;
		wr(8'he5, 8'hff);
		chk(txm, e & 8'h7f);
		rd(`PMC_ADDR_TX_MODE, a);
		chk(a, 8'h00);
		$display("test modes done");
		// two bytes back to back, then a starved buffer
		wr(`PMC_ADDR_MASK, 8'h04);
		wr(`PMC_ADDR_RX_MODE, 8'h00);
		rd(`PMC_ADDR_FLAGS, a);
		a = $random(seed);
		b = $random(seed);
		w = {a, b, 8'hff};
		got_q.delete();
		wr(`PMC_ADDR_TX_BYTE, a);
		wr(`PMC_ADDR_TX_MODE, 8'h02);
		for (i = 0; i < 400 && got_q.size() == 0; i++)
			@(posedge clk);
		wr(`PMC_ADDR_TX_BYTE, b);
		for (i = 0; i < 600 && got_q.size() < 12; i++)
			@(posedge clk);
		chk({7'h00, interrupt_out_n}, 8'h00);
		wr(`PMC_ADDR_TX_MODE, 8'h00);
		rd(`PMC_ADDR_FLAGS, v);
		chk(v, 8'h06);
		for (i = 0; i < 12; i++)
			chk(i < got_q.size() ? got_q[i] : 2'bxx, ph(w[23 - 2 * i -: 2]));
		repeat (2) @(posedge clk);
		chk({7'h00, interrupt_out_n}, 8'h01);
		// one scrambled byte; model state is the last 17 bits sent
		s = w[16:0];
		c = $random(seed);
		for (i = 7; i >= 0; i--) begin
			s = {s[15:0], c[i] ^ s[`PMC_TAP_A] ^ s[`PMC_TAP_B]};
			w[16 + i] = s[0];
		end
		got_q.delete();
		wr(`PMC_ADDR_TX_BYTE, c);
		wr(`PMC_ADDR_TX_MODE, 8'h12);
		for (i = 0; i < 200 && got_q.size() < 4; i++)
			@(posedge clk);
		// off before the next byte boundary, so no underflow
		wr(`PMC_ADDR_TX_MODE, 8'h00);
		rd(`PMC_ADDR_FLAGS, v);
		chk(v, 8'h02);
		for (i = 0; i < 4; i++)
			chk(i < got_q.size() ? got_q[i] : 2'bxx, ph(w[23 - 2 * i -: 2]));
		$display("test transmit done");
		// one byte with a mark change, one descrambled, then one with receiver off
		wr(`PMC_ADDR_MASK, 8'h00);
		wr(`PMC_ADDR_RX_MODE, 8'h02);
		// top bit set so the later descrambled byte depends on it
		a = $random(seed) | 8'h80;
		demod.send(a);
		raw_mark_in <= 1'b1;
		repeat (8) @(posedge clk);
		chk({7'h00, interrupt_out_n}, 8'h01);
		rd(`PMC_ADDR_FLAGS, v);
		chk(v, 8'h09);
		rd(`PMC_ADDR_RX_BYTE, v);
		chk(v, a);
		// descrambler state holds the bits received so far
		d = {9'h000, a};
		c = $random(seed);
		for (i = 7; i >= 0; i--) begin
			e[i] = c[i] ^ d[`PMC_TAP_A] ^ d[`PMC_TAP_B];
			d = {d[15:0], c[i]};
		end
		wr(`PMC_ADDR_RX_MODE, 8'h12);
		demod.send(c);
		rd(`PMC_ADDR_RX_BYTE, v);
		chk(v, e);
		rd(`PMC_ADDR_FLAGS, v);
		chk(v, 8'h08);
		wr(`PMC_ADDR_RX_MODE, 8'h00);
		demod.send(~a);
		repeat (8) @(posedge clk);
		rd(`PMC_ADDR_FLAGS, v);
		chk(v, 8'h00);
		$display("test receive done");
		print_verdict();
	end
endmodule
`default_nettype wire
